// file: design/fpp_consts.svh
/*
 Frame bytes, opcodes, status codes and block geometry for the
 flash block programming link. Assumes both ends include it.
*/
// What this block does
// - Erase request: LEN 07H, opcode 22H, two addresses
// - Device erases blocks covering the address range
// - Erase answered by one-byte status frame
// - Program request: SOH, LEN 07H, opcode 40H
// - Programmer keeps program addresses block aligned
// - Data frames: STX, count (00H=256), data, sum, terminator
// - Each write frame answered with two status bytes
// - Final frame both ACK starts internal verify
// - Programmer then sends a status request
// - Internal verify result returned as one-byte status
// - Programmer should then set read-out protection; fpp_host sends no lock command and leaves it to the user
// - Verify request: LEN 07H, opcode 13H, acknowledged
// - Programmer keeps verify addresses block aligned
// - Device compares each byte with flash contents
// - Verify data frames share the write frame layout
// - Each verify frame answered with two status bytes
// - Mismatches reported only in the final frame
`ifndef FPP_CONSTS_SVH
`define FPP_CONSTS_SVH

`define FPP_SOH        8'h01
`define FPP_STX        8'h02
`define FPP_ETX        8'h03
`define FPP_ETB        8'h17
`define FPP_OP_ERASE   8'h22
`define FPP_OP_PROG    8'h40
`define FPP_OP_VERIFY  8'h13
`define FPP_OP_STATUS  8'h70
`define FPP_LEN_ONE    8'h01
`define FPP_LEN_TWO    8'h02
`define FPP_LEN_ADDR   8'h07
`define FPP_ACK        8'h06
`define FPP_NAK        8'h15
`define FPP_BLK_MASK   24'h0003FF

`endif

// file: design/fpp_device.sv
/*
 Device end: parses command and data frames, drives the flash
 handshake and answers with status frames. Assumes a flash macro
 that acks each request once, a programmer on the same clock.
*/
`timescale 1ns/1ps
`include "fpp_consts.svh"
module fpp_device
	import fpp_pkg::*;
(
	// System
	input  wire logic        clock,
	input  wire logic        reset,
	// Programmer link
	fpp_link_if.dev          link,
	// Flash handshake
	output logic             fl_req,
	output fpp_flop_t        fl_op,
	output logic [23:0]      fl_addr,
	output logic [23:0]      fl_end,
	output logic [7:0]       fl_wdata,
	input  wire logic        fl_ack,
	input  wire logic        fl_ok,
	input  wire logic [7:0]  fl_rdata,
	// Status
	output logic             iv_busy
);

	fpp_dst_t   state;
	fpp_mode_t  mode;
	logic       dframe;
	logic [7:0] len;
	logic [7:0] op;
	logic [7:0] sum;
	logic [47:0] arg;
	logic [8:0] cnt;
	logic [8:0] dcnt;
	logic [23:0] addr;
	logic [7:0] held;
	logic       werr;
	logic       mism;
	logic [7:0] iv_res;
	logic [7:0] tx_b [0:5];
	logic [2:0] tx_n;
	logic [2:0] tx_i;

	logic [7:0] b;
	logic [7:0] next_sum;
	logic       take;
	logic       sent;
	logic       cmd_ok;
	logic       dat_ok;
	logic       dat_last;
	logic [8:0] next_cnt;

	assign b        = link.h2d_data;
	assign take     = link.h2d_valid && link.h2d_ready;
	assign sent     = link.d2h_valid && link.d2h_ready;
	assign next_sum = sum + b;
	assign next_cnt = cnt + 9'h001;
	// Sum already holds the checksum byte when the terminator arrives
	assign cmd_ok   = (sum == 8'h00) && (b == `FPP_ETX);
	assign dat_ok   = (sum == 8'h00) && (b == `FPP_ETX || b == `FPP_ETB);
	assign dat_last = (b == `FPP_ETX);

	// Queue a status frame; checksum makes LEN..SUM add to zero
	task automatic reply(input logic two, input logic [7:0] s1, input logic [7:0] s2);
		logic [7:0] cs;
		cs = two ? (8'h00 - (`FPP_LEN_TWO + s1 + s2)) : (8'h00 - (`FPP_LEN_ONE + s1));
		tx_b[0] <= `FPP_STX;
		tx_b[1] <= two ? `FPP_LEN_TWO : `FPP_LEN_ONE;
		tx_b[2] <= s1;
		tx_b[3] <= two ? s2 : cs;
		tx_b[4] <= two ? cs : `FPP_ETX;
		tx_b[5] <= `FPP_ETX;
		tx_n <= two ? 3'd6 : 3'd5;
		tx_i <= 3'd1;
		link.d2h_data <= `FPP_STX;
		link.d2h_valid <= 1'b1;
		link.h2d_ready <= 1'b0;
		state <= S_TX;
	endtask

	always_ff @(posedge clock) begin
		if (reset) begin
			state <= S_IDLE;
			mode <= M_IDLE;
			dframe <= 1'b0;
			len <= 8'h00;
			op <= 8'h00;
			sum <= 8'h00;
			arg <= 48'h000000000000;
			cnt <= 9'h000;
			dcnt <= 9'h000;
			addr <= 24'h000000;
			held <= 8'h00;
			werr <= 1'b0;
			mism <= 1'b0;
			iv_busy <= 1'b0;
			iv_res <= `FPP_NAK;
			tx_n <= 3'd0;
			tx_i <= 3'd0;
			for (int i = 0; i < 6; i++) begin
				tx_b[i] <= 8'h00;
			end
			fl_req <= 1'b0;
			fl_op <= FL_ERASE;
			fl_addr <= 24'h000000;
			fl_end <= 24'h000000;
			fl_wdata <= 8'h00;
			link.h2d_ready <= 1'b1;
			link.d2h_valid <= 1'b0;
			link.d2h_data <= 8'h00;
		end else begin
			// Internal verify runs beside the parser, so status may be polled
			if (iv_busy && fl_ack) begin
				fl_req <= 1'b0;
				iv_busy <= 1'b0;
				iv_res <= fl_ok ? `FPP_ACK : `FPP_NAK;
			end
			case (state)
				S_IDLE: begin
					if (take && b == `FPP_SOH) begin
						dframe <= 1'b0;
						state <= S_LEN;
					end else if (take && b == `FPP_STX && mode != M_IDLE) begin
						dframe <= 1'b1;
						state <= S_LEN;
					end
				end
				S_LEN: begin
					if (take) begin
						len <= b;
						sum <= b;
						cnt <= 9'h000;
						werr <= 1'b0;
						dcnt <= {(b == 8'h00), b};
						state <= dframe ? S_DATA : S_OPC;
					end
				end
				S_OPC: begin
					if (take) begin
						op <= b;
						sum <= next_sum;
						state <= (len <= `FPP_LEN_ONE) ? S_SUM : S_ARG;
					end
				end
				S_ARG: begin
					if (take) begin
						// Start high/mid/low then end high/mid/low
						arg <= {arg[39:0], b};
						sum <= next_sum;
						cnt <= next_cnt;
						if (cnt[7:0] == len - `FPP_LEN_TWO) begin
							state <= S_SUM;
						end
					end
				end
				S_SUM: begin
					if (take) begin
						sum <= next_sum;
						state <= S_END;
					end
				end
				S_DATA: begin
					if (take) begin
						sum <= next_sum;
						held <= b;
						fl_req <= 1'b1;
						fl_op <= (mode == M_PROG) ? FL_WRITE : FL_READ;
						fl_addr <= addr;
						fl_wdata <= b;
						link.h2d_ready <= 1'b0;
						state <= S_FLASH;
					end
				end
				S_FLASH: begin
					if (fl_ack) begin
						fl_req <= 1'b0;
						addr <= addr + 24'h000001;
						cnt <= next_cnt;
						if (mode == M_PROG) begin
							werr <= werr | ~fl_ok;
						end else begin
							mism <= mism | (fl_rdata != held);
						end
						link.h2d_ready <= 1'b1;
						state <= (next_cnt == dcnt) ? S_SUM : S_DATA;
					end
				end
				S_END: begin
					if (take && dframe) begin
						if (mode == M_PROG) begin
							reply(1'b1, dat_ok ? `FPP_ACK : `FPP_NAK, werr ? `FPP_NAK : `FPP_ACK);
						end else begin
							// Verify result stays ACK until the last frame
							reply(1'b1, dat_ok ? `FPP_ACK : `FPP_NAK,
								(dat_last && mism) ? `FPP_NAK : `FPP_ACK);
						end
						if (dat_last) begin
							mode <= M_IDLE;
						end
						if (dat_last && mode == M_PROG && dat_ok && !werr) begin
							fl_req <= 1'b1;
							fl_op <= FL_IVER;
							fl_addr <= arg[47:24];
							fl_end <= arg[23:0];
							iv_busy <= 1'b1;
						end
					end else if (take && (!cmd_ok || (iv_busy && op != `FPP_OP_STATUS))) begin
						// Bad frame, or range command while verify still runs
						reply(1'b0, `FPP_NAK, 8'h00);
					end else if (take) begin
						case (op)
							`FPP_OP_ERASE: begin
								if (len == `FPP_LEN_ADDR) begin
									fl_req <= 1'b1;
									fl_op <= FL_ERASE;
									fl_addr <= arg[47:24];
									fl_end <= arg[23:0];
									link.h2d_ready <= 1'b0;
									state <= S_ERASE;
								end else begin
									reply(1'b0, `FPP_NAK, 8'h00);
								end
							end
							`FPP_OP_PROG: begin
								mode <= M_PROG;
								addr <= arg[47:24];
								fl_end <= arg[23:0];
								iv_res <= `FPP_NAK;
								reply(1'b0, (len == `FPP_LEN_ADDR) ? `FPP_ACK : `FPP_NAK, 8'h00);
							end
							`FPP_OP_VERIFY: begin
								mode <= M_VER;
								addr <= arg[47:24];
								fl_end <= arg[23:0];
								mism <= 1'b0;
								reply(1'b0, (len == `FPP_LEN_ADDR) ? `FPP_ACK : `FPP_NAK, 8'h00);
							end
							`FPP_OP_STATUS: begin
								link.h2d_ready <= 1'b0;
								state <= S_STWAIT;
							end
							default: begin
								reply(1'b0, `FPP_NAK, 8'h00);
							end
						endcase
					end
				end
				S_ERASE: begin
					if (fl_ack) begin
						fl_req <= 1'b0;
						reply(1'b0, fl_ok ? `FPP_ACK : `FPP_NAK, 8'h00);
					end
				end
				S_STWAIT: begin
					// Holds the link until the verify outcome is known
					if (!iv_busy) begin
						reply(1'b0, iv_res, 8'h00);
					end
				end
				S_TX: begin
					if (sent) begin
						if (tx_i == tx_n) begin
							link.d2h_valid <= 1'b0;
							link.h2d_ready <= 1'b1;
							state <= S_IDLE;
						end else begin
							link.d2h_data <= tx_b[tx_i];
							tx_i <= tx_i + 3'd1;
						end
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

endmodule

// file: design/fpp_host.sv
/*
 Programmer end: turns user commands and data bytes into frames
 and returns the status bytes. Assumes a device on the same clock.
*/
`timescale 1ns/1ps
`include "fpp_consts.svh"
module fpp_host
	import fpp_pkg::*;
(
	// System
	input  wire logic        clock,
	input  wire logic        reset,
	// Device link
	fpp_link_if.host         link,
	// Commands
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire fpp_cmd_t    cmd_kind,
	input  wire logic [23:0] cmd_start,
	input  wire logic [23:0] cmd_end,
	input  wire logic [7:0]  cmd_len,
	input  wire logic        cmd_final,
	// Data bytes
	input  wire logic        wr_valid,
	output logic             wr_ready,
	input  wire logic [7:0]  wr_data,
	// Answers
	output logic             rsp_valid,
	output logic             rsp_refused,
	output logic             rsp_bad,
	output logic [7:0]       rsp_first,
	output logic [7:0]       rsp_second
);

	fpp_hst_t   state;
	logic [7:0] hb [0:10];
	logic [3:0] hn;
	logic [3:0] hi;
	logic       to_data;
	logic [7:0] hs;
	logic [8:0] dc;
	logic [8:0] dtot;
	logic       term;
	logic       prog_seq;
	logic       fin;
	logic [3:0] ri;
	logic [7:0] rlen;
	logic [7:0] rs;

	logic       hsent;
	logic       rcv;
	logic       aligned;
	logic [7:0] op;
	logic [7:0] b;

	assign hsent = link.h2d_valid && link.h2d_ready;
	assign rcv   = link.d2h_valid && link.d2h_ready;
	assign b     = link.d2h_data;
	// Misaligned ranges are never put on the link
	assign aligned = ((cmd_start & `FPP_BLK_MASK) == 24'h000000)
		&& ((cmd_end & `FPP_BLK_MASK) == `FPP_BLK_MASK);
	assign op = (cmd_kind == C_ERASE) ? `FPP_OP_ERASE :
		(cmd_kind == C_PROG) ? `FPP_OP_PROG : `FPP_OP_VERIFY;

	// Load a command frame and put its first byte on the link
	task automatic launch_cmd(input logic [7:0] o, input logic rng, input logic [23:0] s, input logic [23:0] e);
		logic [7:0] l;
		logic [7:0] cs;
		l = rng ? `FPP_LEN_ADDR : `FPP_LEN_ONE;
		cs = 8'h00 - (l + o + (rng ? (s[23:16] + s[15:8] + s[7:0] + e[23:16] + e[15:8] + e[7:0]) : 8'h00));
		hb[0] <= `FPP_SOH;
		hb[1] <= l;
		hb[2] <= o;
		hb[3] <= rng ? s[23:16] : cs;
		hb[4] <= rng ? s[15:8] : `FPP_ETX;
		hb[5] <= s[7:0];
		hb[6] <= e[23:16];
		hb[7] <= e[15:8];
		hb[8] <= e[7:0];
		hb[9] <= cs;
		hb[10] <= `FPP_ETX;
		hn <= rng ? 4'd11 : 4'd5;
		hi <= 4'd1;
		to_data <= 1'b0;
		link.h2d_data <= `FPP_SOH;
		link.h2d_valid <= 1'b1;
		state <= H_SEND;
	endtask

	always_ff @(posedge clock) begin
		if (reset) begin
			state <= H_IDLE;
			for (int i = 0; i < 11; i++) begin
				hb[i] <= 8'h00;
			end
			hn <= 4'd0;
			hi <= 4'd0;
			to_data <= 1'b0;
			hs <= 8'h00;
			dc <= 9'h000;
			dtot <= 9'h000;
			term <= 1'b0;
			prog_seq <= 1'b0;
			fin <= 1'b0;
			ri <= 4'd0;
			rlen <= 8'h00;
			rs <= 8'h00;
			cmd_ready <= 1'b1;
			wr_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_refused <= 1'b0;
			rsp_bad <= 1'b0;
			rsp_first <= 8'h00;
			rsp_second <= 8'h00;
			link.h2d_data <= 8'h00;
			link.h2d_valid <= 1'b0;
			link.d2h_ready <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			case (state)
				H_IDLE: begin
					if (cmd_valid && cmd_ready) begin
						rsp_refused <= 1'b0;
						fin <= 1'b0;
						if (cmd_kind == C_DATA) begin
							hb[0] <= `FPP_STX;
							hb[1] <= cmd_len;
							hn <= 4'd2;
							hi <= 4'd1;
							to_data <= 1'b1;
							hs <= cmd_len;
							dc <= 9'h000;
							dtot <= {(cmd_len == 8'h00), cmd_len};
							term <= cmd_final;
							fin <= cmd_final && prog_seq;
							link.h2d_data <= `FPP_STX;
							link.h2d_valid <= 1'b1;
							cmd_ready <= 1'b0;
							state <= H_SEND;
						end else if (cmd_kind == C_STATUS) begin
							launch_cmd(`FPP_OP_STATUS, 1'b0, 24'h000000, 24'h000000);
							cmd_ready <= 1'b0;
						end else if (!aligned) begin
							rsp_refused <= 1'b1;
							rsp_valid <= 1'b1;
						end else begin
							prog_seq <= (cmd_kind == C_PROG);
							launch_cmd(op, 1'b1, cmd_start, cmd_end);
							cmd_ready <= 1'b0;
						end
					end
				end
				H_SEND: begin
					if (hsent) begin
						if (hi == hn) begin
							link.h2d_valid <= 1'b0;
							if (to_data) begin
								wr_ready <= 1'b1;
								state <= H_DATA;
							end else begin
								ri <= 4'd0;
								rs <= 8'h00;
								link.d2h_ready <= 1'b1;
								state <= H_RX;
							end
						end else begin
							link.h2d_data <= hb[hi];
							hi <= hi + 4'd1;
						end
					end
				end
				H_DATA: begin
					if (wr_valid && wr_ready) begin
						link.h2d_data <= wr_data;
						link.h2d_valid <= 1'b1;
						wr_ready <= 1'b0;
						hs <= hs + wr_data;
						dc <= dc + 9'h001;
						state <= H_DOUT;
					end
				end
				H_DOUT: begin
					if (hsent) begin
						if (dc == dtot) begin
							hb[1] <= term ? `FPP_ETX : `FPP_ETB;
							link.h2d_data <= 8'h00 - hs;
							hn <= 4'd2;
							hi <= 4'd1;
							to_data <= 1'b0;
							state <= H_SEND;
						end else begin
							link.h2d_valid <= 1'b0;
							wr_ready <= 1'b1;
							state <= H_DATA;
						end
					end
				end
				H_RX: begin
					if (rcv) begin
						ri <= ri + 4'd1;
						if (ri != 4'd0) begin
							rs <= rs + b;
						end
						if (ri == 4'd1) begin
							rlen <= b;
						end
						if (ri == 4'd2) begin
							rsp_first <= b;
							rsp_second <= 8'h00;
						end
						if (ri == 4'd3 && rlen == `FPP_LEN_TWO) begin
							rsp_second <= b;
						end
						if (ri > 4'd1 && ri == rlen[3:0] + 4'd3) begin
							link.d2h_ready <= 1'b0;
							rsp_bad <= (rs != 8'h00) || (b != `FPP_ETX);
							rsp_valid <= 1'b1;
							if (fin && rsp_first == `FPP_ACK && rsp_second == `FPP_ACK) begin
								fin <= 1'b0;
								prog_seq <= 1'b0; // read-out lock is the user's next step
								launch_cmd(`FPP_OP_STATUS, 1'b0, 24'h000000, 24'h000000);
							end else begin
								cmd_ready <= 1'b1;
								state <= H_IDLE;
							end
						end
					end
				end
				default: begin
					state <= H_IDLE;
				end
			endcase
		end
	end

endmodule

// file: design/fpp_link_if.sv
/*
 Byte link between programmer and device: one valid/ready byte
 channel each way. Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface fpp_link_if;
	logic [7:0] h2d_data;
	logic       h2d_valid;
	logic       h2d_ready;
	logic [7:0] d2h_data;
	logic       d2h_valid;
	logic       d2h_ready;

	modport dev (
		input  h2d_data, h2d_valid, d2h_ready,
		output h2d_ready, d2h_data, d2h_valid
	);

	modport host (
		output h2d_data, h2d_valid, d2h_ready,
		input  h2d_ready, d2h_data, d2h_valid
	);
endinterface

// file: design/fpp_pkg.sv
/*
 Types shared by both ends of the flash programming link.
 Assumes the constants header is compiled alongside.
*/
package fpp_pkg;
	typedef enum logic [1:0] {
		FL_ERASE = 2'b00,
		FL_WRITE = 2'b01,
		FL_READ  = 2'b10,
		FL_IVER  = 2'b11
	} fpp_flop_t;

	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_PROG = 2'b01,
		M_VER  = 2'b10
	} fpp_mode_t;

	typedef enum logic [3:0] {
		S_IDLE   = 4'h0,
		S_LEN    = 4'h1,
		S_OPC    = 4'h2,
		S_ARG    = 4'h3,
		S_SUM    = 4'h4,
		S_END    = 4'h5,
		S_DATA   = 4'h6,
		S_FLASH  = 4'h7,
		S_ERASE  = 4'h8,
		S_STWAIT = 4'h9,
		S_TX     = 4'hA
	} fpp_dst_t;

	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_SEND = 3'h1,
		H_DATA = 3'h2,
		H_DOUT = 3'h3,
		H_RX   = 3'h4
	} fpp_hst_t;

	typedef enum logic [2:0] {
		C_ERASE  = 3'h0,
		C_PROG   = 3'h1,
		C_VERIFY = 3'h2,
		C_DATA   = 3'h3,
		C_STATUS = 3'h4
	} fpp_cmd_t;
endpackage

// file: tb/fpp_link_asserts.sv
/*
 Frame checker for the programmer/device byte link.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "fpp_consts.svh"
module fpp_link_asserts (
	// System
	input wire logic       clock,
	input wire logic       reset,
	// Link
	input wire logic [7:0] h2d_data,
	input wire logic       h2d_valid,
	input wire logic       h2d_ready,
	input wire logic [7:0] d2h_data,
	input wire logic       d2h_valid,
	input wire logic       d2h_ready
);
	logic [8:0] h_idx, d_idx, h_n, d_n;
	logic [7:0] h_sum, d_sum;
	logic       h_soh, turn;
	wire        h_go  = h2d_valid && h2d_ready;
	wire        d_go  = d2h_valid && d2h_ready;
	wire        h_end = h_go && h_idx > 9'h001 && h_idx == h_n + 9'h003;
	wire        d_end = d_go && d_idx > 9'h001 && d_idx == d_n + 9'h003;

	// Position, length and sum of the host frame
	always_ff @(posedge clock) begin
		if (reset) begin
			h_idx <= 9'h000;
			h_n   <= 9'h000;
			h_sum <= 8'h00;
			h_soh <= 1'b0;
		end else if (h_go) begin
			h_idx <= h_end ? 9'h000 : h_idx + 9'h001;
			h_sum <= (h_idx == 9'h000) ? 8'h00 : h_sum + h2d_data;
			if (h_idx == 9'h000) begin
				h_soh <= (h2d_data == `FPP_SOH);
			end
			if (h_idx == 9'h001) begin
				h_n <= (h2d_data == 8'h00) ? 9'h100 : {1'b0, h2d_data};
			end
		end
	end

	// Position, length and sum of the status frame
	always_ff @(posedge clock) begin
		if (reset) begin
			d_idx <= 9'h000;
			d_n   <= 9'h000;
			d_sum <= 8'h00;
		end else if (d_go) begin
			d_idx <= d_end ? 9'h000 : d_idx + 9'h001;
			d_sum <= (d_idx == 9'h000) ? 8'h00 : d_sum + d2h_data;
			if (d_idx == 9'h001) begin
				d_n <= {1'b0, d2h_data};
			end
		end
	end

	// Whose turn it is on the link
	always_ff @(posedge clock) begin
		if (reset || d_end) begin
			turn <= 1'b0;
		end else if (h_end) begin
			turn <= 1'b1;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	sequence host_done_s;
		h_end;
	endsequence

	sequence answer_s;
		##[1:400] d2h_valid;
	endsequence

	host_hold_a: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
		else $error("host byte changed before taken");
	dev_hold_a: assert property (d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
		else $error("status byte changed before taken");
	frame_head_a: assert property (h2d_valid && h_idx == 9'h000 |-> h2d_data inside {`FPP_SOH, `FPP_STX})
		else $error("host frame starts wrong");
	cmd_len_a: assert property (h_go && h_soh && h_idx == 9'h001 |-> h2d_data inside {`FPP_LEN_ADDR, `FPP_LEN_ONE})
		else $error("command byte count wrong");
	host_term_a: assert property (h_end |-> h2d_data == `FPP_ETX || (!h_soh && h2d_data == `FPP_ETB))
		else $error("host terminator wrong");
	host_sum_a: assert property (h_go && h_idx > 9'h001 && h_idx == h_n + 9'h002 |-> h2d_data == 8'h00 - h_sum)
		else $error("host checksum wrong");
	dev_head_a: assert property (d2h_valid && d_idx == 9'h000 |-> d2h_data == `FPP_STX)
		else $error("status frame starts wrong");
	dev_len_a: assert property (d_go && d_idx == 9'h001 |-> d2h_data inside {`FPP_LEN_ONE, `FPP_LEN_TWO})
		else $error("status byte count wrong");
	dev_tail_a: assert property (d_end |-> d2h_data == `FPP_ETX && $past(d2h_data) == 8'h00 - $past(d_sum))
		else $error("status frame tail wrong");
	turn_order_a: assert property (d2h_valid |-> turn && !h2d_valid)
		else $error("frames out of turn");
	answer_time_a: assert property (host_done_s |-> answer_s)
		else $error("no status frame in time");
endmodule

// file: tb/tb.sv
/*
 Bench: host and device joined by the link, flash macro modelled here.
 Assumes the design files and the link checker are compiled first.
*/
`timescale 1ns/1ps
`include "fpp_consts.svh"
module tb;
	import fpp_pkg::*;
	localparam logic [23:0] PS = 24'h000800;
	localparam logic [23:0] PE = 24'h000BFF;
	logic        clock = 1'b0, reset = 1'b1;
	logic        fl_req, fl_ack = 1'b0, fl_ok = 1'b0, iv_busy;
	fpp_flop_t   fl_op, fail_op = FL_ERASE;
	logic [23:0] fl_addr, fl_end, cmd_start = 24'h0, cmd_end = 24'h0, op_s, op_e;
	logic [7:0]  fl_wdata, fl_rdata = 8'h00, cmd_len = 8'h00, wr_data = 8'h00;
	logic        cmd_valid = 1'b0, cmd_ready, cmd_final = 1'b0, wr_valid = 1'b0, wr_ready;
	fpp_cmd_t    cmd_kind = C_ERASE;
	logic        rsp_valid, rsp_refused, rsp_bad;
	logic [7:0]  rsp_first, rsp_second;
	logic [7:0]  mem [int], img [int];
	bit          fail_arm, iv_fail;
	int          failures, total_checks, cycles, fl_cnt, ptr, seed_v;

	fpp_link_if link_i ();
	fpp_device i_fpp_device (.clock(clock), .reset(reset), .link(link_i), .fl_req(fl_req), .fl_op(fl_op),
		.fl_addr(fl_addr), .fl_end(fl_end), .fl_wdata(fl_wdata), .fl_ack(fl_ack), .fl_ok(fl_ok),
		.fl_rdata(fl_rdata), .iv_busy(iv_busy));
	fpp_host i_fpp_host (.clock(clock), .reset(reset), .link(link_i), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_start(cmd_start), .cmd_end(cmd_end),
		.cmd_len(cmd_len), .cmd_final(cmd_final), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_data(wr_data), .rsp_valid(rsp_valid), .rsp_refused(rsp_refused), .rsp_bad(rsp_bad),
		.rsp_first(rsp_first), .rsp_second(rsp_second));
	fpp_link_asserts i_fpp_link_asserts (.clock(clock), .reset(reset), .h2d_data(link_i.h2d_data),
		.h2d_valid(link_i.h2d_valid), .h2d_ready(link_i.h2d_ready), .d2h_data(link_i.d2h_data),
		.d2h_valid(link_i.d2h_valid), .d2h_ready(link_i.d2h_ready));

	always #12.5 clock = ~clock;

	// Flash macro: random latency, one-cycle ack, optional one-shot failure
	always @(negedge clock) begin
		fl_ack = 1'b0;
		if (fl_req === 1'b1 && !reset) begin
			if (fl_cnt == 0) fl_cnt = 1 + int'($urandom % 3);
			fl_cnt--;
			if (fl_cnt == 0) begin
				fl_ok = !(fail_arm && fl_op == fail_op);
				if (!fl_ok) fail_arm = 1'b0;
				case (fl_op)
					FL_ERASE: begin op_s = fl_addr; op_e = fl_end; end
					FL_WRITE: if (fl_ok) mem[fl_addr] = fl_wdata;
					FL_READ: fl_rdata = mem[fl_addr];
					FL_IVER: begin op_s = fl_addr; op_e = fl_end; fl_ok = !iv_fail; end
				endcase
				fl_ack = 1'b1;
			end
		end
	end

	// Ceiling well above the few thousand cycles the run needs
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			stop_test();
		end
	end

	function automatic logic [7:0] verdict(input bit bad);
		return bad ? `FPP_NAK : `FPP_ACK;
	endfunction

	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_addr(input string what, input logic [23:0] exp, input logic [23:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic run_cmd(input fpp_cmd_t k, input logic [23:0] s, input logic [23:0] e, input logic [7:0] n,
		input logic f);
		while (cmd_ready !== 1'b1) @(negedge clock);
		cmd_valid = 1'b1;
		cmd_kind = k;
		cmd_start = s;
		cmd_end = e;
		cmd_len = n;
		cmd_final = f;
		@(negedge clock);
		cmd_valid = 1'b0;
	endtask

	// Refused commands leave the status bytes stale, so only the flag counts
	// A refusal pulses in the cycle of the take, so look before waiting
	task automatic expect_rsp(input logic [7:0] e1, input logic [7:0] e2, input logic erf);
		while (rsp_valid !== 1'b1) begin @(posedge clock); #1; end
		chk_byte("refused", {7'h00, erf}, {7'h00, rsp_refused});
		if (!erf) begin
			chk_byte("first status", e1, rsp_first);
			chk_byte("second status", e2, rsp_second);
			chk_byte("answer bad", 8'h00, {7'h00, rsp_bad});
		end
		@(posedge clock);
		@(negedge clock);
	endtask

	task automatic send_frame(input logic [7:0] n, input logic f, input bit prog, input int flip);
		int cnt;
		cnt = (n == 8'h00) ? 256 : int'(n);
		run_cmd(C_DATA, 24'h000000, 24'h000000, n, f);
		for (int i = 0; i < cnt; i++) begin
			if (prog) img[ptr] = 8'($urandom);
			while (wr_ready !== 1'b1 || $urandom % 4 == 0) begin wr_valid = 1'b0; @(negedge clock); end
			wr_valid = 1'b1;
			wr_data = img[ptr] ^ ((i == flip) ? 8'h01 : 8'h00);
			ptr++;
			@(negedge clock);
		end
		wr_valid = 1'b0;
	endtask

	task automatic stop_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		seed_v = $urandom(32'hC6CE);
		repeat (20) @(negedge clock);
		reset = 1'b0;
		// Erase, then erase with the flash refusing, then a misaligned program refused
		run_cmd(C_ERASE, 24'h000400, PE, 8'h00, 1'b0);
		expect_rsp(verdict(0), 8'h00, 1'b0);
		chk_addr("erase start", 24'h000400, op_s);
		chk_addr("erase end", PE, op_e);
		fail_op = FL_ERASE;
		fail_arm = 1'b1;
		run_cmd(C_ERASE, 24'h000400, PE, 8'h00, 1'b0);
		expect_rsp(verdict(1), 8'h00, 1'b0);
		run_cmd(C_PROG, PS + 24'h000001, PE, 8'h00, 1'b0);
		expect_rsp(8'h00, 8'h00, 1'b1);
		// Program: 256-byte frame, frame with a failed write, final with failed verify
		run_cmd(C_PROG, PS, PE, 8'h00, 1'b0);
		expect_rsp(verdict(0), 8'h00, 1'b0);
		ptr = PS;
		send_frame(8'h00, 1'b0, 1'b1, -1);
		expect_rsp(verdict(0), verdict(0), 1'b0);
		fail_op = FL_WRITE;
		fail_arm = 1'b1;
		send_frame(8'hFF, 1'b0, 1'b1, -1);
		expect_rsp(verdict(0), verdict(1), 1'b0);
		iv_fail = 1'b1;
		send_frame(8'h05, 1'b1, 1'b1, -1);
		expect_rsp(verdict(0), verdict(0), 1'b0);
		expect_rsp(verdict(1), 8'h00, 1'b0);
		chk_byte("verify busy", 8'h00, {7'h00, iv_busy});
		chk_addr("verify start", PS, op_s);
		chk_addr("verify end", PE, op_e);
		for (int a = PS; a < PS + 256; a++) chk_byte("flash byte", img[a], mem[a]);
		iv_fail = 1'b0;
		run_cmd(C_PROG, PS, PE, 8'h00, 1'b0);
		expect_rsp(verdict(0), 8'h00, 1'b0);
		ptr = PS;
		send_frame(8'(1 + $urandom % 8), 1'b1, 1'b1, -1);
		expect_rsp(verdict(0), verdict(0), 1'b0);
		expect_rsp(verdict(0), 8'h00, 1'b0);
		// Verify: early mismatch held back to the final frame, then a clean pass
		run_cmd(C_VERIFY, PS, PE, 8'h00, 1'b0);
		expect_rsp(verdict(0), 8'h00, 1'b0);
		ptr = PS;
		send_frame(8'h10, 1'b0, 1'b0, 3);
		expect_rsp(verdict(0), verdict(0), 1'b0);
		send_frame(8'h10, 1'b1, 1'b0, -1);
		expect_rsp(verdict(0), verdict(1), 1'b0);
		run_cmd(C_VERIFY, PS, PE, 8'h00, 1'b0);
		expect_rsp(verdict(0), 8'h00, 1'b0);
		ptr = PS;
		send_frame(8'h00, 1'b1, 1'b0, -1);
		expect_rsp(verdict(0), verdict(0), 1'b0);
		stop_test();
	end
endmodule
